// File: design/i2cra_pin_sync.sv
// i2cra_pin_sync: two-flop synchroniser and spike filter per input bit
// assumes asynchronous pin inputs and one system clock
`timescale 1ns/1ns
`default_nettype none
module i2cra_pin_sync
#(
    parameter int W = 2,
    parameter int FILT = 1
)
(
    input wire logic clk,           // system clock
    input wire logic resetn,        // synchronous reset, active low
    input wire logic [W-1:0] din,   // raw pin levels
    output logic [W-1:0] dout       // synchronised, filtered levels
);
    localparam int CW = $clog2(FILT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILT - 1);

    initial
    begin
        if (W < 1 || FILT < 1)
            $error("i2cra_pin_sync: W and FILT must be at least 1");
    end

    logic [W-1:0] s1;
    logic [W-1:0] s2;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s1 <= '1;
            s2 <= '1;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a level passes once it has held for FILT cycles
    for (genvar i = 0; i < W; i++)
    begin : g_filt
        logic [CW-1:0] cnt;
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                cnt <= '0;
                dout[i] <= 1'b1;
            end
            else if (s2[i] == dout[i])
                cnt <= '0;
            else if (cnt == CNT_LAST)
            begin
                cnt <= '0;
                dout[i] <= s2[i];
            end
            else
                cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: design/i2cra_pkg.sv
// i2cra_pkg: constants and types of the two-wire register access port
// assumes a 20 MHz system clock; the link is sampled, not clocked
package i2cra_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int SPIKE_NS = 50;
    // longest spike rounds down, never below one cycle
    localparam int SPIKE_CYC = (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (SPIKE_NS / CLK_PERIOD_NS);

    localparam logic [4:0] ADDR_FIXED = 5'h08;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_SWRESET = 8'h06;
    localparam logic [7:0] GC_RELOAD = 8'h04;
    localparam logic [7:0] ADDR_REG_OFS = 8'hca;
    localparam int ADDR_REG_LSB = 2;
    localparam int ADDR_REG_MSB = 6;
    localparam logic [7:0] SHUTTER_ADDR = 8'ha4;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] STRETCH_CYC = 2'h2;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_RX    = 6'h02,
        ST_RXACK = 6'h04,
        ST_TX    = 6'h08,
        ST_TXACK = 6'h10,
        ST_IGN   = 6'h20
    } i2cra_state_e;

    typedef enum logic [3:0] {
        K_ADDR  = 4'h1,
        K_REG   = 4'h2,
        K_DATA  = 4'h4,
        K_GCALL = 4'h8
    } i2cra_kind_e;

endpackage

// File: design/i2cra_slave.sv
// i2cra_slave: two-wire target port giving a host the 256-byte
// register space; general call reset and address reload
// assumes the register file answers a read strobe one cycle later
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - seven-bit target addressing only, no ten-bit
// - device may stretch clock, host waits
// - general call then 0x06 gives soft reset
// - general call then 0x04 reloads address bits
// - straps restore two address bits on both
// - address is 01000, strap1, strap0, direction
// - straps let four devices share bus
// - follows host clock up to 1MHz, unconfigured
// - multi write stores bytes, pointer increments
// - single read: register address, then read
// - multi read returns successive bytes until NACK
// - shadowed values apply from next frame
// - transfer lengths 3, 2+n, 4, 3+n
// - shutter register write starts a frame
// - serial port is only register path
// - 256 byte locations, pointer eight bits
module i2cra_slave
    import i2cra_pkg::*;
#(
    parameter int FILT = SPIKE_CYC
)
(
    input wire logic clk,             // system clock, 20 MHz
    input wire logic resetn,          // synchronous reset, active low
    input wire logic scl_i,           // clock pin level
    output logic scl_o,               // clock pin drive value, always 0
    output logic scl_oe,              // pulls clock low while stretching
    input wire logic sda_i,           // data pin level
    output logic sda_o,               // data pin drive value, always 0
    output logic sda_oe,              // pulls data low
    input wire logic strap_addr_bit0, // address strap 0
    input wire logic strap_addr_bit1, // address strap 1
    input wire logic [7:0] addr_reg_val, // stored address register
    output logic [7:0] reg_addr,      // register file address
    output logic [7:0] reg_wdata,     // register file write data
    output logic reg_we,              // register write pulse
    output logic reg_re,              // register read pulse
    input wire logic [7:0] reg_rdata, // read data, one cycle after reg_re
    input wire logic frame_busy,      // frame acquisition running
    output logic frame_start,         // pulse: start a frame
    output logic shadow_apply,        // pulse: load shadowed values
    output logic soft_reset           // pulse: device-wide soft reset
);
    initial
    begin
        if (FILT < 1)
            $error("i2cra_slave: FILT must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and bus events
    logic [3:0] pins;
    logic scl_q;
    logic sda_q;
    logic scl_d;
    logic sda_d;

    i2cra_pin_sync #(.W(4), .FILT(FILT)) u_sync
    (
        .clk(clk),
        .resetn(resetn),
        .din({strap_addr_bit1, strap_addr_bit0, sda_i, scl_i}),
        .dout(pins)
    );

    assign scl_q = pins[0];
    assign sda_q = pins[1];

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end

    // edges of the host clock at any rate whose levels hold FILT cycles, no speed setting
    wire scl_rise = scl_q & ~scl_d;
    wire scl_fall = ~scl_q & scl_d;
    wire start_det = scl_q & scl_d & sda_d & ~sda_q;
    wire stop_det = scl_q & scl_d & ~sda_d & sda_q;

    ////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    logic [1:0] strap_q;
    logic [1:0] strap_cnt;
    logic strap_ok;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            strap_cnt <= '0;
            strap_ok <= 1'b0;
            strap_q <= 2'h0;
        end
        else if (!strap_ok)
        begin
            strap_cnt <= strap_cnt + 1'b1;
            if (strap_cnt == STRAP_WAIT)
            begin
                strap_ok <= 1'b1;
                strap_q <= pins[3:2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer state
    i2cra_state_e st;
    i2cra_kind_e kind;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] txsh;
    logic [7:0] ptr;
    logic [4:0] dev_hi;
    logic rx_done;
    logic go_tx;
    logic ack_ok;
    logic fetch;
    logic [1:0] scnt;
    logic gc_reset;
    logic gc_reload;
    logic busy_d;

    wire [7:0] rx_byte = shreg;
    // upper bits 01000 until a reload from addr_reg_val, which can set a ten-bit header pattern
    wire [6:0] dev_addr = {dev_hi, strap_q};
    wire addr_hit = rx_byte[7:1] == dev_addr;
    wire gc_hit = rx_byte == GC_ADDR;
    wire gc_cmd_ok = rx_byte == GC_SWRESET || rx_byte == GC_RELOAD;
    wire byte_end = scl_fall & rx_done;
    wire fetch_end = fetch && scnt == STRETCH_CYC - 2'h1;
    wire soft_clr = soft_reset;

    always_ff @(posedge clk)
    begin
        if (!resetn || soft_clr)
        begin
            st <= ST_IDLE;
            kind <= K_ADDR;
            bitcnt <= '0;
            shreg <= '0;
            txsh <= '0;
            ptr <= PTR_RESET;
            rx_done <= 1'b0;
            go_tx <= 1'b0;
            ack_ok <= 1'b0;
            fetch <= 1'b0;
            scnt <= '0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            reg_addr <= '0;
            reg_wdata <= '0;
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            frame_start <= 1'b0;
            gc_reset <= 1'b0;
            gc_reload <= 1'b0;
        end
        else
        begin
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            frame_start <= 1'b0;
            if (start_det)
            begin
                // repeated start keeps the pointer
                st <= ST_RX;
                kind <= K_ADDR;
                bitcnt <= '0;
                rx_done <= 1'b0;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                fetch <= 1'b0;
                gc_reset <= 1'b0;
                gc_reload <= 1'b0;
            end
            else if (stop_det)
            begin
                st <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                fetch <= 1'b0;
            end
            else
            begin
                case (st)
                    ST_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shreg <= {shreg[6:0], sda_q};
                            bitcnt <= bitcnt + 1'b1;
                            rx_done <= bitcnt == LAST_BIT;
                        end
                        else if (byte_end)
                        begin
                            rx_done <= 1'b0;
                            st <= ST_RXACK;
                            sda_oe <= 1'b1;
                            go_tx <= 1'b0;
                            case (kind)
                                K_ADDR:
                                begin
                                    if (addr_hit)
                                    begin
                                        go_tx <= rx_byte[0];
                                        kind <= K_REG;
                                    end
                                    else if (gc_hit)
                                        kind <= K_GCALL;
                                    else
                                    begin
                                        st <= ST_IGN;
                                        sda_oe <= 1'b0;
                                    end
                                end
                                K_REG:
                                begin
                                    ptr <= rx_byte;
                                    kind <= K_DATA;
                                end
                                K_DATA:
                                begin
                                    // each byte stored, pointer moves on
                                    reg_addr <= ptr;
                                    reg_wdata <= rx_byte;
                                    reg_we <= 1'b1;
                                    ptr <= ptr + PTR_STEP;
                                    frame_start <= ptr == SHUTTER_ADDR;
                                end
                                K_GCALL:
                                begin
                                    gc_reset <= rx_byte == GC_SWRESET;
                                    gc_reload <= rx_byte == GC_RELOAD;
                                    if (!gc_cmd_ok)
                                    begin
                                        st <= ST_IGN;
                                        sda_oe <= 1'b0;
                                    end
                                end
                                default:
                                begin
                                    st <= ST_IGN;
                                    sda_oe <= 1'b0;
                                end
                            endcase
                        end
                    end
                    ST_RXACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                            bitcnt <= '0;
                            gc_reset <= 1'b0;
                            gc_reload <= 1'b0;
                            if (gc_reset || gc_reload)
                                st <= ST_IGN;
                            else if (go_tx)
                            begin
                                st <= ST_TX;
                                fetch <= 1'b1;
                                scnt <= '0;
                                reg_addr <= ptr;
                                reg_re <= 1'b1;
                                scl_oe <= 1'b1;
                            end
                            else
                                st <= ST_RX;
                        end
                    end
                    ST_TX:
                    begin
                        if (fetch)
                        begin
                            scnt <= scnt + 1'b1;
                            if (fetch_end)
                            begin
                                // data ready: drive msb, free the clock
                                fetch <= 1'b0;
                                txsh <= reg_rdata;
                                sda_oe <= ~reg_rdata[7];
                                scl_oe <= 1'b0;
                            end
                        end
                        else if (scl_fall)
                        begin
                            if (bitcnt == LAST_BIT)
                            begin
                                sda_oe <= 1'b0;
                                st <= ST_TXACK;
                                ack_ok <= 1'b0;
                            end
                            else
                            begin
                                bitcnt <= bitcnt + 1'b1;
                                txsh <= {txsh[6:0], 1'b0};
                                sda_oe <= ~txsh[6];
                            end
                        end
                    end
                    ST_TXACK:
                    begin
                        if (scl_rise)
                        begin
                            if (!sda_q)
                            begin
                                ack_ok <= 1'b1;
                                ptr <= ptr + PTR_STEP;
                            end
                            else
                            begin
                                ptr <= ptr + PTR_STEP;
                                st <= ST_IGN;
                            end
                        end
                        else if (scl_fall && ack_ok)
                        begin
                            st <= ST_TX;
                            bitcnt <= '0;
                            fetch <= 1'b1;
                            scnt <= '0;
                            reg_addr <= ptr;
                            reg_re <= 1'b1;
                            scl_oe <= 1'b1;
                        end
                    end
                    ST_IGN:
                    begin
                        sda_oe <= 1'b0;
                    end
                    default:
                    begin
                        st <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general call actions, taken as the acknowledge bit ends
    wire gc_do_reset = st == ST_RXACK && scl_fall && gc_reset;
    wire gc_do_reload = st == ST_RXACK && scl_fall && gc_reload;

    always_ff @(posedge clk)
    begin
        if (!resetn || soft_clr)
            dev_hi <= ADDR_FIXED;
        else if (gc_do_reload)
            dev_hi <= addr_reg_val[ADDR_REG_MSB:ADDR_REG_LSB];
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            soft_reset <= 1'b0;
            shadow_apply <= 1'b0;
            busy_d <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            soft_reset <= gc_do_reset;
            busy_d <= frame_busy;
            shadow_apply <= frame_busy & ~busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_stretch;
        scl_oe [*2] ##1 !scl_oe;
    endsequence

    chk_nomatch_noack: assert property (st == ST_IGN |-> !sda_oe)
        else $error("acknowledge driven while ignoring");
    chk_start_restart: assert property (
        start_det && !soft_reset |=> st == ST_RX && kind == K_ADDR)
        else $error("start did not restart transfer");
    chk_stop_idle: assert property (
        stop_det && !soft_reset |=> st == ST_IDLE && !sda_oe)
        else $error("stop did not idle port");
    chk_soft_reset: assert property (
        gc_do_reset |=> soft_reset ##1 (st == ST_IDLE && ptr == PTR_RESET
        && dev_hi == ADDR_FIXED))
        else $error("software reset not applied");
    chk_addr_reload: assert property (
        gc_do_reload |=>
        dev_hi == $past(addr_reg_val[ADDR_REG_MSB:ADDR_REG_LSB]))
        else $error("address reload wrong");
    // the capture edge itself changes strap_q, so look from the next cycle
    chk_strap_bits: assert property (
        strap_ok && $past(strap_ok) |-> dev_addr[1:0] == strap_q
        && $stable(strap_q))
        else $error("strap address bits altered");
    chk_write_incr: assert property (
        reg_we |-> ptr == reg_addr + PTR_STEP)
        else $error("write pointer did not advance");
    chk_stretch_hold: assert property (
        $rose(scl_oe) |-> reg_re ##0 s_stretch)
        else $error("clock stretch length wrong");
    chk_shutter_frame: assert property (
        reg_we |-> frame_start == (reg_addr == SHUTTER_ADDR))
        else $error("shutter write did not start frame");
    chk_shadow_apply: assert property (
        $rose(frame_busy) |=> shadow_apply ##1 !shadow_apply)
        else $error("shadow values not applied at frame start");
endmodule
`default_nettype wire

// File: test/i2c_register_access_slave_tb.sv
// i2c_register_access_slave_tb: self-checking bench of the register port
// assumes i2cra_host as bus controller and a behavioural register file
`timescale 1ns/1ns
`default_nettype none
module i2c_register_access_slave_tb;
    import i2cra_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strap0 = 1'b0;
    logic strap1 = 1'b0;
    logic [7:0] addr_reg_val = 8'h00;
    logic [7:0] reg_rdata = 8'h00;
    logic frame_busy = 1'b0;
    wire scl_line, sda_line;
    logic scl_oe, sda_oe, reg_we, reg_re, frame_start, shadow_apply, soft_reset;
    logic [7:0] reg_addr, reg_wdata;
    logic [7:0] mem [256];
    logic [7:0] wa [$];
    logic [7:0] wd [$];
    int n_fs = 0, n_sa = 0, n_sr = 0, n_st = 0;
    int miscompares = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    i2cra_slave i_dut (.clk(clk), .resetn(resetn), .scl_i(scl_line),
        .scl_o(), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(),
        .sda_oe(sda_oe), .strap_addr_bit0(strap0), .strap_addr_bit1(strap1),
        .addr_reg_val(addr_reg_val), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .frame_busy(frame_busy),
        .frame_start(frame_start), .shadow_apply(shadow_apply),
        .soft_reset(soft_reset));
    i2cra_host i_host (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl_line(scl_line), .sda_line(sda_line));
    // register file model: read data one cycle after the strobe
    always @(posedge clk)
    begin
        if (reg_re)
            reg_rdata <= mem[reg_addr];
        if (reg_we)
        begin
            mem[reg_addr] <= reg_wdata;
            wa.push_back(reg_addr);
            wd.push_back(reg_wdata);
        end
        n_fs += frame_start;
        n_sa += shadow_apply;
        n_sr += soft_reset;
        n_st += scl_oe;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp, input string what);
        chk8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic snd(input logic [7:0] b, input logic exp);
        logic a;
        i_host.wbyte(b, a);
        chk1(a, exp, "acknowledge");
    endtask
    task automatic probe(input logic [6:0] dev, input logic exp);
        i_host.start_c();
        snd({dev, 1'b0}, exp);
        i_host.stop_c();
    endtask
    task automatic gcall(input logic [7:0] cmd, input logic exp);
        i_host.start_c();
        snd(GC_ADDR, 1'b1);
        snd(cmd, exp);
        i_host.stop_c();
    endtask
    task automatic do_reset;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] ra, input int n);
        wa.delete();
        wd.delete();
        i_host.start_c();
        snd(8'h40, 1'b1);
        snd(ra, 1'b1);
        for (int i = 0; i < n; i++)
            snd(~ra + 8'(i), 1'b1);
        i_host.stop_c();
        chk8(8'(wa.size()), 8'(n), "write count");
        // writes judged at the register file, never read back at once
        for (int i = 0; i < n; i++)
        begin
            chk8(wa[i], ra + 8'(i), "write address");
            chk8(wd[i], ~ra + 8'(i), "write data");
        end
    endtask
    task automatic rd(input logic [7:0] ra, input int n);
        logic [7:0] d;
        int s0;
        s0 = n_st;
        i_host.start_c();
        snd(8'h40, 1'b1);
        snd(ra, 1'b1);
        i_host.start_c();
        snd(8'h41, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            i_host.rbyte(i < n - 1, d);
            chk8(d, (ra + 8'(i)) ^ 8'h5a, "read data");
        end
        i_host.stop_c();
        chk1(n_st > s0, 1'b1, "stretch");
    endtask
    task automatic t_gcall;
        int s0;
        s0 = n_sr;
        gcall(GC_SWRESET, 1'b1);
        chk8(8'(n_sr - s0), 8'h01, "soft reset");
        addr_reg_val <= 8'h30;
        gcall(GC_RELOAD, 1'b1);
        probe(7'h30, 1'b1);
        probe(7'h20, 1'b0);
        gcall(GC_SWRESET, 1'b1);
        probe(7'h20, 1'b1);
        gcall(8'h05, 1'b0);
    endtask
    task automatic t_frame;
        int f0;
        int a0;
        f0 = n_fs;
        wr(SHUTTER_ADDR, 1);
        chk8(8'(n_fs - f0), 8'h01, "frame start");
        a0 = n_sa;
        frame_busy <= 1'b1;
        repeat (3) @(posedge clk);
        chk8(8'(n_sa - a0), 8'h01, "shadow apply");
        frame_busy <= 1'b0;
    endtask
    task automatic t_straps;
        strap0 <= 1'b1;
        strap1 <= 1'b1;
        do_reset();
        probe(7'h23, 1'b1);
        probe(7'h20, 1'b0);
        addr_reg_val <= 8'h30;
        gcall(GC_RELOAD, 1'b1);
        probe(7'h33, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
        do_reset();
        wr(8'h10, 1);
        wr(8'h30, 3);
        rd(8'h40, 1);
        rd(8'h50, 3);
        probe(7'h21, 1'b0);
        probe(7'h78, 1'b0);
        t_gcall();
        t_frame();
        t_straps();
        close_out();
    end
    initial
    begin
        #2000000;
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        close_out();
    end
endmodule
`default_nettype wire

// File: test/i2cra_host.sv
// i2cra_host: behavioural bus controller on the clock and data lines
// assumes open-drain lines with pull-ups and the 20 MHz bench clock
`timescale 1ns/1ns
`default_nettype none
module i2cra_host
(
    input wire logic clk,       // bench clock
    input wire logic scl_oe,    // target pulls clock low
    input wire logic sda_oe,    // target pulls data low
    output wire logic scl_line, // resolved clock line
    output wire logic sda_line  // resolved data line
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // pull-ups: a released line reads high
    assign scl_line = ~(scl_low | scl_oe);
    assign sda_line = ~(sda_low | sda_oe);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // release the clock, then wait while the target stretches it
    task automatic rise;
        int k;
        k = 0;
        scl_low <= 1'b0;
        @(posedge clk);
        while (!scl_line && k < 400)
        begin
            k++;
            @(posedge clk);
        end
    endtask
    task automatic start_c;
        sda_low <= 1'b0;
        // clock low as long as for a bit, so an acknowledge is let go first
        cyc(6);
        rise();
        cyc(3);
        sda_low <= 1'b1;
        cyc(4);
        scl_low <= 1'b1;
    endtask
    task automatic stop_c;
        cyc(2);
        sda_low <= 1'b1;
        cyc(2);
        rise();
        cyc(3);
        sda_low <= 1'b0;
        cyc(6);
    endtask
    // one clock period of 400 ns: low 6 cycles, high 2 cycles
    task automatic bitx(input logic b, output logic r);
        cyc(2);
        sda_low <= ~b;
        cyc(4);
        rise();
        @(negedge clk);
        r = sda_line;
        @(posedge clk);
        scl_low <= 1'b1;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(~ack, r);
    endtask
endmodule
`default_nettype wire
